// File: core/calib_pkg.sv
package calib_pkg;

   // ************************************************************
   // Command pins and decode
   // ************************************************************
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] ba;
      logic [15:0] addr;
   } cmd_pins_t;

   localparam logic [3:0] CMD_MODE_SET = 4'h0;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;

   localparam logic [2:0] BA_MODE_ZERO = 3'h0;
   localparam logic [2:0] BA_MODE_THREE = 3'h3;

   // ************************************************************
   // Mode register fields
   // ************************************************************
   localparam int MR3_ENABLE_BIT = 2;
   localparam int MR3_LOC_LSB = 0;
   localparam int MR0_BL_LSB = 0;
   localparam int CHOP_SEL_BIT = 12;
   localparam int NIBBLE_SEL_BIT = 2;

   localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
   localparam logic [1:0] BL_FIXED_CHOP = 2'h2;

   localparam logic [1:0] LOC_CALIB = 2'h0;
   localparam logic [7:0] CALIB_PATTERN = 8'haa;
   localparam logic [7:0] RESERVED_PATTERN = 8'h00;

   localparam logic [1:0] MR3_RESET_LOC = 2'h0;
   localparam logic MR3_RESET_ENABLE = 1'b0;
   localparam logic [1:0] MR0_RESET_BL = 2'h0;

   // ************************************************************
   // Part width and burst timing
   // ************************************************************
   localparam logic [1:0] WIDTH_X4 = 2'h0;
   localparam logic [1:0] WIDTH_X8 = 2'h1;
   localparam logic [1:0] WIDTH_X16 = 2'h2;

   localparam int READ_LATENCY_CK = 5;
   localparam int LAT_EDGES = 2 * READ_LATENCY_CK;
   localparam logic [3:0] BEATS_FULL = 4'h8;
   localparam logic [3:0] BEATS_CHOP = 4'h4;
   localparam logic [2:0] POS_LOWER = 3'h0;
   localparam logic [2:0] POS_UPPER = 3'h4;

   typedef struct packed {
      logic valid;
      logic chop;
      logic upper;
   } read_desc_t;

   typedef struct packed {
      logic data;
      logic last;
   } beat_t;

   localparam int BEAT_W = 2;

endpackage : calib_pkg

// File: core/beat_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module beat_buffer #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
      bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready = (count_reg != (PTR_W + 1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= bump(wr_ptr_reg);
         if (pop) rd_ptr_reg <= bump(rd_ptr_reg);
         count_reg <= count_reg + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
      end
   end

endmodule : beat_buffer

`default_nettype wire

// File: core/pattern_readout.sv
// Overview of operation
// - While enabled, every read form is served from the pattern register.
// - While enabled, location select bits A1..A0 choose what each read returns.
// - Enable clear means normal array reads and writes, location select ignored.
// - A pattern read gives one logical bit per beat on all data pins.
// - Four-bit part: pin 0 carries the bit, other lanes copy or drive zero.
// - Eight-bit part: pin 0 carries the bit, pins 7..1 copy or drive zero.
// - Sixteen-bit part: bit 0 of each byte carries it, bits 7..1 copy or zero.
// - Eight-beat bursts use A2 low and return positions 0 through 7.
// - Chopped bursts return 0..3 with A2 low, 4..7 with A2 high.
// - Chop select bit picks chop or full burst when on-the-fly is enabled.
// - All other address bits are ignored during pattern reads.
// - Pattern reads keep ordinary read latency and command timing.
// - Burst position 0 is the source LSB, position 7 its MSB.
// - Location 00 returns alternating 0,1 for full and either chopped half.
`timescale 1ns/100ps
`default_nettype none

module pattern_readout (
   input wire logic clk,
   input wire logic reset,
   input wire logic ck,
   input wire calib_pkg::cmd_pins_t cmd_pins,
   input wire logic [1:0] part_width,
   input wire logic copy_lanes,
   output logic [15:0] dq_out,
   output logic [15:0] dq_oe,
   output logic pattern_mode,
   output logic array_read,
   output logic array_write,
   output logic read_busy
);
   import calib_pkg::*;

   // ************************************************************
   // Pin synchronisers and link clock edges
   // ************************************************************
   // The clock pin runs through three stages and the command pins through two, so a
   // command sampled at a detected edge lines up with the clock level.
   logic ck_s1_reg;
   logic ck_s2_reg;
   logic ck_s3_reg;
   cmd_pins_t cmd_s1_reg;
   cmd_pins_t cmd_s2_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         ck_s1_reg <= 1'b0;
         ck_s2_reg <= 1'b0;
         ck_s3_reg <= 1'b0;
         cmd_s1_reg <= '1;
         cmd_s2_reg <= '1;
      end else begin
         ck_s1_reg <= ck;
         ck_s2_reg <= ck_s1_reg;
         ck_s3_reg <= ck_s2_reg;
         cmd_s1_reg <= cmd_pins;
         cmd_s2_reg <= cmd_s1_reg;
      end
   end

   wire ck_rise = ck_s2_reg && !ck_s3_reg;
   wire ck_edge = ck_s2_reg != ck_s3_reg;

   // ************************************************************
   // Command decode
   // ************************************************************
   wire [3:0] cmd_code = {cmd_s2_reg.cs_n, cmd_s2_reg.ras_n, cmd_s2_reg.cas_n,
                          cmd_s2_reg.we_n};
   wire is_mode_set = ck_rise && (cmd_code == CMD_MODE_SET);
   wire is_read = ck_rise && (cmd_code == CMD_READ);
   wire is_write = ck_rise && (cmd_code == CMD_WRITE);
   wire set_mr3 = is_mode_set && (cmd_s2_reg.ba == BA_MODE_THREE);
   wire set_mr0 = is_mode_set && (cmd_s2_reg.ba == BA_MODE_ZERO);

   logic enable_reg;
   logic [1:0] loc_reg;
   logic [1:0] bl_mode_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         enable_reg <= MR3_RESET_ENABLE;
         loc_reg <= MR3_RESET_LOC;
         bl_mode_reg <= MR0_RESET_BL;
      end else begin
         if (set_mr3) begin
            enable_reg <= cmd_s2_reg.addr[MR3_ENABLE_BIT];
            loc_reg <= cmd_s2_reg.addr[MR3_LOC_LSB +: 2];
         end
         if (set_mr0) bl_mode_reg <= cmd_s2_reg.addr[MR0_BL_LSB +: 2];
      end
   end

   // Only A2 and the chop select bit are looked at for a pattern
   // read; column bits 1..0 are assumed low as the controller must drive them.
   wire pattern_read = is_read && enable_reg;
   wire chop_now = (bl_mode_reg == BL_FIXED_CHOP) ||
                   ((bl_mode_reg == BL_ON_THE_FLY) &&
                    !cmd_s2_reg.addr[CHOP_SEL_BIT]);
   wire upper_now = chop_now && cmd_s2_reg.addr[NIBBLE_SEL_BIT];

   // ************************************************************
   // Read latency line, one stage per link clock edge
   // ************************************************************
   // A line rather than a single counter lets back-to-back reads overlap.
   read_desc_t lat_reg [LAT_EDGES];
   read_desc_t lat_head;
   assign lat_head = '{valid: pattern_read, chop: chop_now, upper: upper_now};

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < LAT_EDGES; i++) lat_reg[i] <= '0;
      end else if (ck_edge) begin
         lat_reg[0] <= ck_rise ? lat_head : '0;
         for (int i = 1; i < LAT_EDGES; i++) lat_reg[i] <= lat_reg[i-1];
      end
   end

   wire read_due = ck_edge && lat_reg[LAT_EDGES-1].valid;

   // ************************************************************
   // Beat generator
   // ************************************************************
   logic [2:0] pos_reg;
   logic [3:0] left_reg;
   logic [2:0] pos_next;
   logic [3:0] left_next;
   logic buf_in_ready;
   wire gen_push = (left_reg != 4'h0) && buf_in_ready;
   wire [7:0] source = (loc_reg == LOC_CALIB) ? CALIB_PATTERN
                                              : RESERVED_PATTERN;
   beat_t gen_beat;
   assign gen_beat = '{data: source[pos_reg], last: (left_reg == 4'h1)};

   always_comb begin
      pos_next = pos_reg;
      left_next = left_reg;
      if (gen_push) begin
         pos_next = pos_reg + 3'h1;
         left_next = left_reg - 4'h1;
      end
      if (read_due) begin
         pos_next = lat_reg[LAT_EDGES-1].upper ? POS_UPPER : POS_LOWER;
         left_next = lat_reg[LAT_EDGES-1].chop ? BEATS_CHOP : BEATS_FULL;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pos_reg <= 3'h0;
         left_reg <= 4'h0;
      end else begin
         pos_reg <= pos_next;
         left_reg <= left_next;
      end
   end

   // ************************************************************
   // Beat buffer and data pins
   // ************************************************************
   logic [BEAT_W-1:0] buf_out_data;
   logic buf_out_valid;
   beat_t out_beat;
   assign out_beat = beat_t'(buf_out_data);

   beat_buffer #(
      .WIDTH(BEAT_W),
      .DEPTH(2)
   ) u_beats (
      .clk(clk),
      .reset(reset),
      .in_data(gen_beat),
      .in_valid(left_reg != 4'h0),
      .in_ready(buf_in_ready),
      .out_data(buf_out_data),
      .out_valid(buf_out_valid),
      .out_ready(ck_edge)
   );

   // Lane 0 of each byte always carries the bit; the others copy it or sit low.
   function automatic logic [15:0] lanes(input logic b, input logic [1:0] w,
                                         input logic cp);
      logic [7:0] byte_val;
      byte_val = {{7{b & cp}}, b};
      case (w)
         WIDTH_X4: lanes = {12'h000, byte_val[3:0]};
         WIDTH_X8: lanes = {8'h00, byte_val};
         WIDTH_X16: lanes = {byte_val, byte_val};
         default: lanes = {8'h00, byte_val};
      endcase
   endfunction : lanes

   function automatic logic [15:0] lane_mask(input logic [1:0] w);
      case (w)
         WIDTH_X4: lane_mask = 16'h000f;
         WIDTH_X16: lane_mask = 16'hffff;
         default: lane_mask = 16'h00ff;
      endcase
   endfunction : lane_mask

   wire beat_out = ck_edge && buf_out_valid;

   always_ff @(posedge clk) begin
      if (reset) begin
         dq_out <= 16'h0000;
         dq_oe <= 16'h0000;
      end else if (ck_edge) begin
         dq_out <= beat_out ? lanes(out_beat.data, part_width, copy_lanes) : 16'h0000;
         dq_oe <= beat_out ? lane_mask(part_width) : 16'h0000;
      end
   end

   // ************************************************************
   // Status and array hand-off
   // ************************************************************
   // Writes while enabled are simply dropped; the controller must not send them.
   always_ff @(posedge clk) begin
      if (reset) begin
         pattern_mode <= 1'b0;
         array_read <= 1'b0;
         array_write <= 1'b0;
         read_busy <= 1'b0;
      end else begin
         pattern_mode <= enable_reg;
         array_read <= is_read && !enable_reg;
         array_write <= is_write && !enable_reg;
         // Busy also covers the beat still standing on the pins, so it falls
         // together with the drive enable rather than one beat early.
         read_busy <= (left_next != 4'h0) || buf_out_valid ||
                      (!ck_edge && (dq_oe != 16'h0000));
      end
   end

endmodule : pattern_readout

`default_nettype wire

// File: dv/pattern_readout_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module pattern_readout_asserts (
   input wire logic clk,
   input wire logic reset,
   input wire logic ck,
   input wire calib_pkg::cmd_pins_t cmd_pins,
   input wire logic [1:0] part_width,
   input wire logic copy_lanes,
   input wire logic [15:0] dq_out,
   input wire logic [15:0] dq_oe,
   input wire logic pattern_mode,
   input wire logic array_read,
   input wire logic array_write,
   input wire logic read_busy
);
   import calib_pkg::*;
   logic [7:0] run_reg;
   wire drive = |dq_oe;
   wire [7:0] run_next = drive ? run_reg + 8'h01 : 8'h00;
   wire [15:0] mask = (part_width == WIDTH_X4) ? 16'h000f :
      (part_width == WIDTH_X16) ? 16'hffff : 16'h00ff;
   wire [15:0] lead = (part_width == WIDTH_X16) ? 16'h0101 : 16'h0001;
   always_ff @(posedge clk) begin
      run_reg <= reset ? 8'h00 : run_next;
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   // A beat stands one link half period, four system clocks at the bench rate.
   sequence beat_hold;
      $stable(dq_out) [*3];
   endsequence
   a_array_quiet: assert property (
      pattern_mode && $past(pattern_mode) |-> !array_read && !array_write)
      else $error("array access while readout enabled");
   a_oe_mask: assert property (drive |-> dq_oe == mask)
      else $error("drive enable does not match part width");
   a_lanes_copy: assert property (
      drive && copy_lanes |-> dq_out == (dq_out[0] ? mask : 16'h0000))
      else $error("copied lanes differ from lane zero");
   a_lanes_zero: assert property (
      drive && !copy_lanes |-> dq_out == (dq_out[0] ? lead : 16'h0000))
      else $error("spare lanes not driven low");
   a_beat_stands: assert property (drive && $changed(dq_out) |=> beat_hold)
      else $error("beat shorter than a half period");
   a_burst_len: assert property (
      $fell(drive) |-> run_reg != 8'h00 && run_reg[3:0] == 4'h0)
      else $error("burst is not a whole number of four beats");
   a_busy_drive: assert property (drive |-> read_busy)
      else $error("driving data while not busy");
   a_read_pulse: assert property (array_read |=> !array_read)
      else $error("array read pulse too long");
   a_write_pulse: assert property (array_write |=> !array_write)
      else $error("array write pulse too long");
endmodule : pattern_readout_asserts
`default_nettype wire

// File: dv/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_model (
   output var logic ck,
   output var calib_pkg::cmd_pins_t cmd_pins
);
   import calib_pkg::*;
   initial begin
      ck = 1'b0;
      cmd_pins = '1;
   end
   // The link clock stands still between frames; released pins are inverted
   // so that a stale command can never look valid.
   task automatic send(input logic [3:0] code, input logic [2:0] ba,
         input logic [15:0] addr, input int extra);
      cmd_pins = {code, ba, addr};
      #16 ck = 1'b1;
      #16 ck = 1'b0;
      cmd_pins = {1'b1, ~code[2:0], ~ba, ~addr};
      repeat (extra) begin
         #16 ck = 1'b1;
         #16 ck = 1'b0;
      end
   endtask : send
endmodule : ctrl_model
`default_nettype wire

// File: dv/pattern_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pattern_readout_tb;
   import calib_pkg::*;
   logic clk, reset, copy_lanes, ck, pattern_mode, array_read, array_write, read_busy;
   logic [1:0] part_width;
   logic [15:0] dq_out, dq_oe;
   cmd_pins_t cmd_pins;
   int failures = 0, n_compared = 0, rd_e = 0, rd_n = 0, wr_e = 0, wr_n = 0, hold = 0;
   logic en = 1'b0;
   logic [1:0] loc = 2'h0, bl = 2'h0;
   logic [31:0] exp_q[$];
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   pattern_readout u_dut (.clk, .reset, .ck, .cmd_pins, .part_width, .copy_lanes,
      .dq_out, .dq_oe, .pattern_mode, .array_read, .array_write, .read_busy);
   ctrl_model u_ctrl (.ck, .cmd_pins);
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic summarize;
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   // One comparison per beat, taken on the first clock of each beat.
   always @(negedge clk) begin
      if (dq_oe !== 16'h0000) begin
         if (hold == 0) begin
            check({dq_oe, dq_out}, exp_q.size() ? exp_q.pop_front() : 32'hdeadbeef);
         end
         hold = (hold + 1) % 4;
      end else begin
         hold = 0;
      end
      rd_n += array_read;
      wr_n += array_write;
   end
   task automatic mode_register_set_cmd(input logic [2:0] ba, input logic [15:0] addr);
      if (ba == BA_MODE_THREE) begin
         en = addr[MR3_ENABLE_BIT];
         loc = addr[1:0];
      end else begin
         bl = addr[1:0];
      end
      u_ctrl.send(CMD_MODE_SET, ba, addr, 3);
   endtask : mode_register_set_cmd
   task automatic rd(input logic a2, input logic a12, input int extra);
      logic [15:0] addr, m, lead;
      logic chop, b;
      addr = (16'($urandom()) & 16'heff8) | {3'h0, a12, 9'h0, a2, 2'h0};
      chop = (bl == BL_FIXED_CHOP) || (bl == BL_ON_THE_FLY && !a12);
      m = part_width == WIDTH_X4 ? 16'h000f : part_width == WIDTH_X16 ? 16'hffff : 16'h00ff;
      lead = part_width == WIDTH_X16 ? 16'h0101 : 16'h0001;
      if (!en) rd_e++;
      for (int k = 0; k < (chop ? 4 : 8) && en; k++) begin
         b = (loc == LOC_CALIB) && ((k + (chop && a2 ? 4 : 0)) % 2 == 1);
         exp_q.push_back({m, b ? (copy_lanes ? m : lead) : 16'h0000});
      end
      u_ctrl.send(CMD_READ, 3'($urandom()), addr, extra);
   endtask : rd
   task automatic wr;
      if (!en) wr_e++;
      u_ctrl.send(CMD_WRITE, 3'h0, 16'($urandom()), 2);
   endtask : wr
   task automatic finish_test(input string name);
      check(exp_q.size(), 0);
      check(rd_n, rd_e);
      check(wr_n, wr_e);
      $display("test %s done", name);
   endtask : finish_test
   initial begin
      #40000;
      failures++;
      summarize();
   end
   initial begin
      reset = 1'b1;
      part_width = WIDTH_X8;
      copy_lanes = 1'b1;
      void'($urandom(32'h677039bb));
      repeat (2) @(posedge clk);
      #1 reset = 1'b0;
      check({pattern_mode, array_read, array_write, read_busy, dq_oe}, 0);
      repeat (3) @(posedge clk);
      #1 mode_register_set_cmd(BA_MODE_THREE, 16'h0001);
      rd(1'b0, 1'b1, 3);
      rd(1'b0, 1'b1, 12);
      wr;
      wr;
      finish_test("array");
      for (int w = 0; w < 4; w++) begin
         @(posedge clk);
         #1 part_width = w[1:0];
         copy_lanes = (w == 0) ? 1'($urandom()) : !copy_lanes;
         mode_register_set_cmd(BA_MODE_THREE, 16'h0004);
         check(pattern_mode, 1);
         rd(1'b0, 1'b1, 3);
         rd(1'b0, 1'b1, 12);
         if (w == 0) wr;
         mode_register_set_cmd(BA_MODE_THREE, 16'h0000);
         check(pattern_mode, 0);
      end
      finish_test("widths");
      mode_register_set_cmd(BA_MODE_ZERO, {14'h0, BL_FIXED_CHOP});
      mode_register_set_cmd(BA_MODE_THREE, 16'h0004);
      rd(1'b0, 1'b1, 3);
      rd(1'b1, 1'b1, 12);
      mode_register_set_cmd(BA_MODE_THREE, 16'h0000);
      mode_register_set_cmd(BA_MODE_ZERO, {14'h0, BL_ON_THE_FLY});
      mode_register_set_cmd(BA_MODE_THREE, 16'h0004);
      rd(1'b1, 1'b0, 12);
      rd(1'b0, 1'b1, 12);
      mode_register_set_cmd(BA_MODE_THREE, 16'h0000);
      mode_register_set_cmd(BA_MODE_ZERO, 16'h0000);
      finish_test("chop");
      for (int l = 1; l < 4; l++) begin
         mode_register_set_cmd(BA_MODE_THREE, 16'h0004 | 16'(l));
         rd(1'b0, 1'b1, 12);
         mode_register_set_cmd(BA_MODE_THREE, 16'h0000);
      end
      finish_test("reserved");
      rd(1'b0, 1'b1, 12);
      finish_test("exit");
      summarize();
   end
endmodule : pattern_readout_tb
bind pattern_readout pattern_readout_asserts u_asserts (.clk, .reset, .ck, .cmd_pins,
   .part_width, .copy_lanes, .dq_out, .dq_oe, .pattern_mode, .array_read, .array_write,
   .read_busy);
`default_nettype wire
